// file: design/dcss_params.svh
// Constants for the decade counter with seven-segment decode
`ifndef DCSS_PARAMS_SVH
`define DCSS_PARAMS_SVH

`define DCSS_JW          5
`define DCSS_JZERO       5'h00
`define DCSS_SEGW        7
`define DCSS_SEG_ALL     7'h7F
`define DCSS_SEG_OFF     7'h00
`define DCSS_DIGW        4
`define DCSS_PINW        6

`define DCSS_ADDR_CTRL   12'h000
`define DCSS_ADDR_STAT   12'h004
`define DCSS_AW          12

`define DCSS_CTRL_VAR    0
`define DCSS_CTRL_SRST   1
`define DCSS_CTRL_SINH   2
`define DCSS_CTRL_RST    3'h0

`define DCSS_PIN_CLK     0
`define DCSS_PIN_RST     1
`define DCSS_PIN_INH     2
`define DCSS_PIN_DE      3
`define DCSS_PIN_RBI     4
`define DCSS_PIN_LT      5

`define DCSS_REG_RST     32'h0000_0000

`define DCSS_PIN_RST_V   6'h00
`define DCSS_CLK_IDLE    1'b0
`define DCSS_BLANK_IDLE  1'b1
`define DCSS_CARRY_RST   1'b1
`define DCSS_BIT_OFF     1'b0
`define DCSS_SEG_C       2
`define DCSS_RING_MSB    4
`define DCSS_CTRLW       3

`endif

// file: design/dcss_pkg.sv
// Types for the decade counter with seven-segment decode
package dcss_pkg;
	typedef enum logic {
		DCSS_VAR_DISP_EN = 1'b0,
		DCSS_VAR_BLANK   = 1'b1
	} dcss_variant_t;
endpackage

// file: design/dcss_top.sv
// Decade Johnson counter, seven-segment decoder and APB control slave
// Functional notes
// - Five-stage Johnson ring, ten states, decoded
// - High reset level forces zero count
// - Rising clock advances one when enable low
// - Enable high holds the count
// - Illegal ring states return to the cycle
// - Carry completes one period per ten
// - Segments show the current decimal digit
// - Display enable low forces segments low
// - Carry and ungated c ignore display enable
// - Blanking variant segments active high, ungated
// - Blank input low blanks a zero
// - Blank input high shows zero normally
// - Lamp test drives all segments high
// - Counter static, holds without clock edges
//
// Block overview
// The counting ring lives in the pclk domain. The counter clock pin is
// not used as a clock; it is sampled like any other pin and a rising
// level change seen by the synchroniser advances the ring once.
// Because of that the counter pin must stay high and low for at least
// one pclk period each, or an edge is lost. That is the price of
// keeping one clock domain and avoiding a second clock tree.
//
// Pin timing, counted in pclk edges after a pin change
// Edge 1: first synchroniser stage captures the pin
// Edge 2: second stage holds it, edge detect sees the change
// Edge 3: the ring steps, or is forced to zero
// Edge 4: segments, carry and the blank chain output follow
//
// Count reset
// Either the reset pin or the software reset bit holds the ring at
// zero. While held, counter pin edges are ignored, not queued.
//
// Hold
// Either the inhibit pin or the software hold bit stops counting.
// An edge that arrives during the hold is dropped for good.
//
// Ring recovery
// A code outside the ten legal ones is sent to zero on the next pclk edge.
// It cannot arise from the shift itself; it guards against upsets.
//
// Variants, chosen by control bit 0
// Display enable variant: segments gated by the enable pin, the c
// segment and the carry run ungated, the enable is echoed out, and
// the blank chain output stays high.
// Ripple blanking variant: the enable pin no longer gates segments,
// a zero is blanked when the chain input is low, lamp test lights all
// segments and leaves the chain output alone.
//
// Register map
// Control at offset 0: variant, software reset, software hold
// Status at offset 4: ring code, digit and carry, read only
// Any other offset answers with an error and reads zero.
//
// Bus timing
// Ready comes one cycle after the first access cycle, so each access
// lasts two cycles. A write lands at the edge where ready is seen.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ns
`include "dcss_params.svh"

module dcss_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        count_clk,
	input  wire logic        count_reset,
	input  wire logic        count_inhibit,
	input  wire logic        disp_en_in,
	input  wire logic        blank_chain_in,
	input  wire logic        lamp_test,
	output logic      [6:0]  seg,
	output logic             seg_c_ungated,
	output logic             disp_en_out,
	output logic             blank_chain_out,
	output logic             decade_carry
);

	// Ring state to digit; illegal codes give zero but never leave the decoder
	function automatic logic [3:0] dcss_digit(input logic [4:0] j);
		logic [3:0] d;
		d = 4'h0;
		case (j)
			5'h00: d = 4'h0;
			5'h01: d = 4'h1;
			5'h03: d = 4'h2;
			5'h07: d = 4'h3;
			5'h0F: d = 4'h4;
			5'h1F: d = 4'h5;
			5'h1E: d = 4'h6;
			5'h1C: d = 4'h7;
			5'h18: d = 4'h8;
			5'h10: d = 4'h9;
			default: d = 4'h0;
		endcase
		return d;
	endfunction

	// Ten legal codes of the twisted ring
	function automatic logic dcss_legal(input logic [4:0] j);
		logic ok;
		ok = 1'b0;
		case (j)
			5'h00, 5'h01, 5'h03, 5'h07, 5'h0F,
			5'h1F, 5'h1E, 5'h1C, 5'h18, 5'h10: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// Digit to segments, bit 0 is a, bit 6 is g
	function automatic logic [6:0] dcss_segs(input logic [3:0] d);
		logic [6:0] s;
		s = 7'h00;
		case (d)
			4'h0: s = 7'h3F;
			4'h1: s = 7'h06;
			4'h2: s = 7'h5B;
			4'h3: s = 7'h4F;
			4'h4: s = 7'h66;
			4'h5: s = 7'h6D;
			4'h6: s = 7'h7D;
			4'h7: s = 7'h07;
			4'h8: s = 7'h7F;
			4'h9: s = 7'h6F;
			default: s = 7'h00;
		endcase
		return s;
	endfunction

	logic [`DCSS_PINW-1:0] pin_s1_q;
	logic [`DCSS_PINW-1:0] pin_s2_q;
	logic                  clk_prev_q;
	logic [`DCSS_JW-1:0]   ring_q;
	logic [`DCSS_JW-1:0]   ring_d;
	logic [2:0]            ctrl_q;
	logic [6:0]            seg_d;

	wire logic [`DCSS_PINW-1:0] pins_raw = {lamp_test, blank_chain_in, disp_en_in,
	                                        count_inhibit, count_reset, count_clk};

	// First stage may go metastable; only the second stage reads it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q <= `DCSS_PIN_RST_V;
		end else begin
			pin_s1_q <= pins_raw;
		end
	end

	// Second stage; every pin is settled here before logic sees it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s2_q <= `DCSS_PIN_RST_V;
		end else begin
			pin_s2_q <= pin_s1_q;
		end
	end

	// Previous clock pin level; resets to the idle low, so no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_prev_q <= `DCSS_CLK_IDLE;
		end else begin
			clk_prev_q <= pin_s2_q[`DCSS_PIN_CLK];
		end
	end

	wire logic clk_s     = pin_s2_q[`DCSS_PIN_CLK];
	wire logic rst_s     = pin_s2_q[`DCSS_PIN_RST];
	wire logic inh_s     = pin_s2_q[`DCSS_PIN_INH];
	wire logic de_s      = pin_s2_q[`DCSS_PIN_DE];
	wire logic rbi_s     = pin_s2_q[`DCSS_PIN_RBI];
	wire logic lt_s      = pin_s2_q[`DCSS_PIN_LT];
	wire logic var_blank = (ctrl_q[`DCSS_CTRL_VAR] == dcss_pkg::DCSS_VAR_BLANK);

	wire logic clk_rise  = clk_s & ~clk_prev_q;
	wire logic inhibit   = inh_s | ctrl_q[`DCSS_CTRL_SINH];
	wire logic zero_req  = rst_s | ctrl_q[`DCSS_CTRL_SRST];

	wire logic [4:0] ring_shift = {ring_q[3:0], ~ring_q[4]};

	// Reset dominates; otherwise step on an enabled edge, else hold
	always_comb begin
		ring_d = ring_q;
		if (zero_req) begin
			ring_d = `DCSS_JZERO;
		end else if (!dcss_legal(ring_q)) begin
			ring_d = `DCSS_JZERO;
		end else if (clk_rise && !inhibit) begin
			ring_d = ring_shift;
		end
	end

	// plain flops, state is held while no edge arrives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_q <= `DCSS_JZERO;
		end else begin
			ring_q <= ring_d;
		end
	end

	wire logic [3:0] digit     = dcss_digit(ring_q);
	wire logic [6:0] seg_dec   = dcss_segs(digit);
	wire logic       is_zero   = (digit == 4'h0);
	// blank a zero when the chain input is low
	// a high chain input shows the zero
	wire logic       blank_now = ~rbi_s & is_zero;

	// Segment selection per variant
	always_comb begin
		seg_d = seg_dec;
		if (var_blank) begin
			if (lt_s) begin
				seg_d = `DCSS_SEG_ALL;
			end else if (blank_now) begin
				seg_d = `DCSS_SEG_OFF;
			end else begin
				seg_d = seg_dec;
			end
		end else begin
			seg_d = de_s ? seg_dec : `DCSS_SEG_OFF;
		end
	end

	// Segments are registered, so they trail the count by one pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg <= `DCSS_SEG_OFF;
		end else begin
			seg <= seg_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_c_ungated <= `DCSS_BIT_OFF;
		end else begin
			seg_c_ungated <= seg_dec[`DCSS_SEG_C];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_en_out <= `DCSS_BIT_OFF;
		end else begin
			disp_en_out <= de_s;
		end
	end

	// low only on a zero with the chain input low, lamp test or not
	// feeds the neighbouring digit's chain input
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blank_chain_out <= `DCSS_BLANK_IDLE;
		end else begin
			blank_chain_out <= ~(var_blank & blank_now);
		end
	end

	// high for 0..4, low for 5..9, rises on 9 to 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decade_carry <= `DCSS_CARRY_RST;
		end else begin
			decade_carry <= ~ring_q[`DCSS_RING_MSB];
		end
	end

	// APB decode: one wait state, answer registered
	wire logic       acc      = psel & penable & ~pready;
	wire logic       hit_ctrl = (paddr == `DCSS_ADDR_CTRL);
	wire logic       hit_stat = (paddr == `DCSS_ADDR_STAT);
	wire logic       mapped   = hit_ctrl | hit_stat;
	// Write lands at the edge where the master sees ready high
	wire logic       wr_ctrl  = psel & penable & pready & pwrite & hit_ctrl;
	wire logic [31:0] rd_mux  = hit_ctrl ? {29'h0000_0000, ctrl_q} :
	                            hit_stat ? {19'h0_0000, decade_carry, digit, 3'h0, ring_q} :
	                            `DCSS_REG_RST;

	// Control register: variant, software reset, software hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `DCSS_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q <= pwdata[`DCSS_CTRLW-1:0];
		end
	end

	// Ready is a one-cycle pulse, one cycle after the first access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= `DCSS_BIT_OFF;
		end else begin
			pready <= acc;
		end
	end

	// Unmapped addresses answer with an error beside ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= `DCSS_BIT_OFF;
		end else begin
			pslverr <= acc & ~mapped;
		end
	end

	// Read data stands only in the ready cycle, zero otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `DCSS_REG_RST;
		end else begin
			prdata <= (acc && !pwrite) ? rd_mux : `DCSS_REG_RST;
		end
	end

endmodule

// file: testbench/dcss_asserts.sv
// Port-level assertions for the decade counter block
`timescale 1ns/1ns
module dcss_asserts (
	input logic       pclk,
	input logic       presetn,
	input logic       psel,
	input logic       penable,
	input logic       pready,
	input logic       pslverr,
	input logic       disp_en_in,
	input logic [6:0] seg,
	input logic       seg_c_ungated,
	input logic       disp_en_out,
	input logic       blank_chain_out,
	input logic       decade_carry
);
	// Single domain, so clock and reset are given once
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// First access edge of a transfer
	sequence s_access;
		$rose(psel && penable);
	endsequence
	a_access_answer: assert property (s_access |=> pready) else $error("late ready");
	a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
	a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
	a_carry_hold: assert property ($fell(decade_carry) |=> !decade_carry [*8]) else $error("short carry");
	a_seg_legal: assert property (seg inside {7'h00, 7'h7F, 7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
		7'h6F}) else $error("bad pattern");
	a_blank_zero: assert property (!blank_chain_out |-> seg inside {7'h00, 7'h7F}) else $error("lit blank");
	a_ungated_c: assert property (!(seg inside {7'h00, 7'h7F}) |-> seg[2] == seg_c_ungated) else $error("c");
	a_enable_copy: assert property ($changed(disp_en_out) |-> disp_en_out == $past(disp_en_in, 3))
		else $error("enable copy");
endmodule
bind dcss_top dcss_asserts u_asserts (.*);

// file: testbench/dcss_display.sv
// Display model that reads the lit segments back as a digit
`timescale 1ns/1ns
module dcss_display (
	input  logic [6:0] seg,
	output logic [3:0] digit
);
	logic [6:0] pat [10] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07, 7'h7F, 7'h6F};
	// pattern readback; blank or odd patterns read as 15
	always_comb begin
		digit = 4'hF;
		for (int i = 0; i < 10; i++)
			if (seg == pat[i]) digit = i[3:0];
	end
endmodule

// file: testbench/test_dcss_top.sv
// Self-checking bench for the decade counter with segment decode
`timescale 1ns/1ns
module test_dcss_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        count_clk, count_reset, count_inhibit, disp_en_in, blank_chain_in, lamp_test;
	logic [6:0]  seg;
	logic        seg_c_ungated, disp_en_out, blank_chain_out, decade_carry;
	logic [3:0]  digit;
	int          bad_count = 0, samples_checked = 0;
	// Carry in bit 7 above the segments, one row per digit
	logic [7:0]  rows [10] = '{8'hBF, 8'h86, 8'hDB, 8'hCF, 8'hE6, 8'h6D, 8'h7D, 8'h07, 8'h7F, 8'h6F};
	dcss_top dut (.*);
	dcss_display u_display (.seg(seg), .digit(digit));
	// 10 MHz clock
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %h %h", $time, got, exp);
		end
	endtask
	// Transfer held until ready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Pulses stay wide so the pin synchroniser sees each one
	task automatic tick(input int n);
		repeat (n) begin
			count_clk <= 1'b1;
			repeat (4) @(posedge pclk);
			count_clk <= 1'b0;
			repeat (4) @(posedge pclk);
		end
	endtask
	// Display pins reach the outputs three edges after a change, count pins four
	task automatic wt;
		repeat (4) @(posedge pclk);
	endtask
	task summarize;
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog, far beyond the roughly 160 cycles needed
	initial begin
		#200000;
		bad_count++;
		summarize;
	end
	// Main sequence: table walk, then hand-written cases
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{count_clk, count_reset, count_inhibit, lamp_test} = '0;
		{disp_en_in, blank_chain_in} = 2'b11;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		chk({blank_chain_out, decade_carry, seg}, 9'h180);
		presetn <= 1'b1;
		wt;
		for (int i = 0; i < 10; i++) begin
			chk({decade_carry, seg}, rows[i]);
			chk(digit, i);
			tick(1);
		end
		chk({decade_carry, seg}, rows[0]);
		tick(1);
		count_inhibit <= 1'b1;
		wt;
		tick(2);
		chk(seg, 7'h06);
		count_inhibit <= 1'b0;
		disp_en_in <= 1'b0;
		wt;
		chk({seg_c_ungated, disp_en_out, seg}, 9'h100);
		disp_en_in <= 1'b1;
		apb(1'b0, 12'h004, '0);
		chk(rd, 32'h0000_1101);
		apb(1'b0, 12'h008, '0);
		chk({err, rd[30:0]}, 32'h8000_0000);
		count_reset <= 1'b1;
		tick(1);
		chk(seg, 7'h3F);
		count_reset <= 1'b0;
		apb(1'b1, 12'h000, 32'h0000_0001);
		// top digit of the chain has its input tied low
		blank_chain_in <= 1'b0;
		wt;
		chk({blank_chain_out, seg}, 8'h00);
		lamp_test <= 1'b1;
		wt;
		chk(seg, 7'h7F);
		lamp_test <= 1'b0;
		blank_chain_in <= 1'b1;
		wt;
		chk({blank_chain_out, seg}, 8'hBF);
		blank_chain_in <= 1'b0;
		disp_en_in <= 1'b0;
		tick(1);
		chk({blank_chain_out, seg}, 8'h86);
		summarize;
	end
endmodule
